/* design/eis_stats.sv */
// Per-interface receive, transmit and size-bin statistics with an Avalon-MM register slave.
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "eis_cfg.svh"

module eis_stats (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire eis_pkg::eis_av_req_s av_req,
  output eis_pkg::eis_av_rsp_s      av_rsp,
  input  wire eis_pkg::eis_rx_s     rx_evt,
  input  wire eis_pkg::eis_tx_s     tx_evt,
  input  wire logic [`EIS_NIF-1:0]  collision,
  input  wire logic [`EIS_NIF-1:0]  link_pin,
  input  wire logic [`EIS_NIF-1:0]  duplex_pin,
  output logic [`EIS_NIF-1:0]       pass_en,
  output logic [`EIS_NIF-1:0]       link_up,
  output logic [`EIS_NIF-1:0]       full_duplex
);
  import eis_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic eis_cnt_t cnt_add(eis_cnt_t c, eis_cnt_t a);
    return c + a;
  endfunction

  // Size bins count good and bad frames alike; frames over 1518 fall in none.
  function automatic logic [`EIS_IDXW-1:0] bin_idx(eis_len_t l);
    if (l == `EIS_LEN_MIN) begin
      return `EIS_C_B64;
    end else if (l < `EIS_LEN_MIN) begin
      return `EIS_C_NONE;
    end else if (l <= `EIS_LEN_127) begin
      return `EIS_C_B127;
    end else if (l <= `EIS_LEN_255) begin
      return `EIS_C_B255;
    end else if (l <= `EIS_LEN_511) begin
      return `EIS_C_B511;
    end else if (l <= `EIS_LEN_1023) begin
      return `EIS_C_B1023;
    end else if (l <= `EIS_LEN_MAX) begin
      return `EIS_C_B1518;
    end else begin
      return `EIS_C_NONE;
    end
  endfunction

  function automatic logic [31:0] rd_word(eis_state_s s, eis_ifc_t f,
                                          logic [`EIS_IDXW-1:0] x);
    logic [31:0] w;
    w = 32'h0;
    if (x < `EIS_IDXW'(`EIS_NCNT)) begin
      w = s.cnt[f][x];
    end else if (x == `EIS_REG_STAT) begin
      w[`EIS_ST_LINK]   = s.link_s2[f];
      w[`EIS_ST_DUPLEX] = s.dup_s2[f];
      w[`EIS_ST_VALID]  = s.valid[f];
      w[`EIS_ST_TEST]   = s.testing[f];
    end else if (x == `EIS_REG_CTRL) begin
      w[`EIS_CT_TEST]   = s.testing[f];
      w[`EIS_CT_VALID]  = s.valid[f];
    end else if (x == `EIS_REG_MTU) begin
      w[`EIS_LENW-1:0]  = s.mtu[f];
    end
    return w;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  eis_state_s          st_ff;
  eis_state_s          nxt_st;
  logic [`EIS_NIF-1:0] clr;
  logic                rx_on;
  logic                tx_on;
  logic [`EIS_IDXW-1:0] bidx;
  eis_ifc_t            a_ifc;
  logic [`EIS_IDXW-1:0] a_idx;

  assign a_ifc = av_req.address[`EIS_AW-1:`EIS_AW-`EIS_IFW];
  assign a_idx = av_req.address[`EIS_IDXW+1:2];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    clr    = '0;
    rx_on  = 1'b0;
    tx_on  = 1'b0;
    bidx   = `EIS_C_NONE;

    nxt_st.link_s1 = link_pin;
    nxt_st.link_s2 = st_ff.link_s1;
    nxt_st.dup_s1  = duplex_pin;
    nxt_st.dup_s2  = st_ff.dup_s1;

    // Read data is captured one edge before the answer, so a counter that moves
    // in that cycle reads its older value.
    case (st_ff.bus)
      EIS_IDLE: begin
        if (av_req.read || av_req.write) begin
          nxt_st.bus   = EIS_ACK;
          nxt_st.rdata = av_req.read ? rd_word(st_ff, a_ifc, a_idx) : 32'h0;
        end
      end
      EIS_ACK: begin
        nxt_st.bus = EIS_IDLE;
        if (av_req.write && a_idx == `EIS_REG_CTRL) begin
          clr[a_ifc]             = av_req.writedata[`EIS_CT_CLEAR];
          nxt_st.testing[a_ifc]  = av_req.writedata[`EIS_CT_TEST];
          nxt_st.valid[a_ifc]    = av_req.writedata[`EIS_CT_VALID];
        end
        if (av_req.write && a_idx == `EIS_REG_MTU) begin
          nxt_st.mtu[a_ifc] = av_req.writedata[`EIS_LENW-1:0];
        end
      end
      default: begin
        nxt_st.bus = EIS_IDLE;
      end
    endcase

    for (int i = 0; i < `EIS_NIF; i++) begin
      // Clear first; an event in the same cycle still counts once.
      for (int j = 0; j < `EIS_NCNT; j++) begin
        nxt_st.cnt[i][j] = clr[i] ? '0 : st_ff.cnt[i][j];
      end
      if (collision[i]) begin
        nxt_st.cnt[i][`EIS_C_COLL] = cnt_add(nxt_st.cnt[i][`EIS_C_COLL], 32'h1);
      end
      // Frames on a testing interface are neither passed nor counted.
      rx_on = rx_evt.valid && rx_evt.ifc == eis_ifc_t'(i) && !st_ff.testing[i];
      tx_on = tx_evt.valid && tx_evt.ifc == eis_ifc_t'(i) && !st_ff.testing[i];
      if (rx_on) begin
        nxt_st.cnt[i][`EIS_C_TOTAL] = cnt_add(nxt_st.cnt[i][`EIS_C_TOTAL], 32'h1);
        nxt_st.cnt[i][`EIS_C_RX_OCT] = cnt_add(nxt_st.cnt[i][`EIS_C_RX_OCT],
                                               {16'h0, rx_evt.len});
        bidx = bin_idx(rx_evt.len);
        if (bidx != `EIS_C_NONE) begin
          nxt_st.cnt[i][bidx] = cnt_add(nxt_st.cnt[i][bidx], 32'h1);
        end
        if (!rx_evt.fcs_ok) begin
          nxt_st.cnt[i][`EIS_C_CRC] = cnt_add(nxt_st.cnt[i][`EIS_C_CRC], 32'h1);
        end
        if (rx_evt.len < `EIS_LEN_MIN) begin
          // Short frames split by check value.
          if (rx_evt.fcs_ok) begin
            nxt_st.cnt[i][`EIS_C_UNDER] = cnt_add(nxt_st.cnt[i][`EIS_C_UNDER], 32'h1);
          end else begin
            nxt_st.cnt[i][`EIS_C_FRAG] = cnt_add(nxt_st.cnt[i][`EIS_C_FRAG], 32'h1);
          end
        end else if (rx_evt.len > `EIS_LEN_MAX) begin
          // Long frames split by check value.
          if (rx_evt.fcs_ok) begin
            nxt_st.cnt[i][`EIS_C_OVER] = cnt_add(nxt_st.cnt[i][`EIS_C_OVER], 32'h1);
          end else begin
            nxt_st.cnt[i][`EIS_C_JAB] = cnt_add(nxt_st.cnt[i][`EIS_C_JAB], 32'h1);
          end
        end
        if (rx_evt.fcs_ok && rx_evt.bcast) begin
          nxt_st.cnt[i][`EIS_C_BCAST] = cnt_add(nxt_st.cnt[i][`EIS_C_BCAST], 32'h1);
        end else if (rx_evt.fcs_ok && rx_evt.mcast) begin
          nxt_st.cnt[i][`EIS_C_MCAST] = cnt_add(nxt_st.cnt[i][`EIS_C_MCAST], 32'h1);
        end
        if (rx_evt.unknown) begin
          nxt_st.cnt[i][`EIS_C_UNKNOWN] = cnt_add(nxt_st.cnt[i][`EIS_C_UNKNOWN], 32'h1);
        end
        if (rx_evt.drop_evt) begin
          nxt_st.cnt[i][`EIS_C_DROP] = cnt_add(nxt_st.cnt[i][`EIS_C_DROP], 32'h1);
        end
      end
      if (tx_on) begin
        if (tx_evt.error) begin
          nxt_st.cnt[i][`EIS_C_OUT_ERR] = cnt_add(nxt_st.cnt[i][`EIS_C_OUT_ERR], 32'h1);
        end else if (tx_evt.discard) begin
          nxt_st.cnt[i][`EIS_C_OUT_DSC] = cnt_add(nxt_st.cnt[i][`EIS_C_OUT_DSC], 32'h1);
        end else begin
          nxt_st.cnt[i][`EIS_C_OUT_OCT] = cnt_add(nxt_st.cnt[i][`EIS_C_OUT_OCT],
                                                  {16'h0, tx_evt.len});
          if (tx_evt.mcast) begin
            nxt_st.cnt[i][`EIS_C_OUT_NUC] = cnt_add(nxt_st.cnt[i][`EIS_C_OUT_NUC], 32'h1);
          end else begin
            nxt_st.cnt[i][`EIS_C_OUT_UC] = cnt_add(nxt_st.cnt[i][`EIS_C_OUT_UC], 32'h1);
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff         <= '0;
      st_ff.bus     <= EIS_IDLE;
      st_ff.mtu     <= {`EIS_NIF{`EIS_MTU_RST}};
      st_ff.valid   <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    av_rsp.readdata    = st_ff.rdata;
    av_rsp.waitrequest = (av_req.read || av_req.write) && st_ff.bus != EIS_ACK;
  end

  assign pass_en     = ~st_ff.testing;
  assign link_up     = st_ff.link_s2;
  assign full_duplex = st_ff.dup_s2;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic chk_rx0;
  assign chk_rx0 = rx_evt.valid && rx_evt.ifc == '0 && !st_ff.testing[0] && !clr[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_total_pkts: assert property (
    chk_rx0 |=> st_ff.cnt[0][`EIS_C_TOTAL] == $past(st_ff.cnt[0][`EIS_C_TOTAL]) + 32'h1)
    else $error("total packet count did not step");
  a_rx_octets: assert property (
    chk_rx0 |=> st_ff.cnt[0][`EIS_C_RX_OCT] ==
      $past(st_ff.cnt[0][`EIS_C_RX_OCT]) + {16'h0, $past(rx_evt.len)})
    else $error("received octets not summed");
  a_frag_count: assert property (
    chk_rx0 && rx_evt.len < `EIS_LEN_MIN && !rx_evt.fcs_ok |=>
      st_ff.cnt[0][`EIS_C_FRAG] == $past(st_ff.cnt[0][`EIS_C_FRAG]) + 32'h1)
    else $error("fragment not counted");
  a_jabber_count: assert property (
    chk_rx0 && rx_evt.len > `EIS_LEN_MAX && !rx_evt.fcs_ok |=>
      st_ff.cnt[0][`EIS_C_JAB] == $past(st_ff.cnt[0][`EIS_C_JAB]) + 32'h1)
    else $error("jabber not counted");
  a_bcast_excl: assert property (
    chk_rx0 && rx_evt.fcs_ok && rx_evt.bcast && rx_evt.mcast |=>
      st_ff.cnt[0][`EIS_C_MCAST] == $past(st_ff.cnt[0][`EIS_C_MCAST]) &&
      st_ff.cnt[0][`EIS_C_BCAST] == $past(st_ff.cnt[0][`EIS_C_BCAST]) + 32'h1)
    else $error("broadcast counted as multicast");
  a_drop_once: assert property (
    chk_rx0 && rx_evt.drop_evt |=>
      st_ff.cnt[0][`EIS_C_DROP] == $past(st_ff.cnt[0][`EIS_C_DROP]) + 32'h1)
    else $error("drop event not counted once");
  a_clear_one: assert property (
    clr[0] && !rx_evt.valid && !tx_evt.valid && collision == '0 |=>
      st_ff.cnt[0][`EIS_C_TOTAL] == '0 && st_ff.cnt[0][`EIS_C_OUT_OCT] == '0 &&
      st_ff.cnt[1][`EIS_C_TOTAL] == $past(st_ff.cnt[1][`EIS_C_TOTAL]))
    else $error("clear hit the wrong interface");
  a_testing_block: assert property (
    st_ff.testing[0] && rx_evt.valid && rx_evt.ifc == '0 && !clr[0] |=>
      $stable(st_ff.cnt[0][`EIS_C_TOTAL]) && !pass_en[0])
    else $error("frame counted on testing interface");
  a_link_sync: assert property (
    link_pin[0] [*3] |-> link_up[0])
    else $error("link indicator late");
  a_bus_answer: assert property (
    st_ff.bus == EIS_IDLE && av_req.read |-> av_rsp.waitrequest ##1 !av_rsp.waitrequest)
    else $error("read not answered in one wait cycle");

  c_bcast_rx: cover property (chk_rx0 && rx_evt.bcast && rx_evt.fcs_ok);
  c_clear: cover property (clr[0] ##1 chk_rx0);
  c_frag: cover property (chk_rx0 && rx_evt.len < `EIS_LEN_MIN && !rx_evt.fcs_ok);
endmodule

/* design/eis_cfg.svh */
// Offsets, field positions, reset values and sizes of the interface statistics block.
`ifndef EIS_CFG_SVH
`define EIS_CFG_SVH
`define EIS_NIF       4
`define EIS_IFW       2
`define EIS_NCNT      23
`define EIS_IDXW      5
`define EIS_AW        9
`define EIS_LENW      16
`define EIS_CNTW      32
`define EIS_C_UNKNOWN 5'h00
`define EIS_C_OUT_OCT 5'h01
`define EIS_C_OUT_UC  5'h02
`define EIS_C_OUT_NUC 5'h03
`define EIS_C_OUT_DSC 5'h04
`define EIS_C_OUT_ERR 5'h05
`define EIS_C_DROP    5'h06
`define EIS_C_COLL    5'h07
`define EIS_C_BCAST   5'h08
`define EIS_C_MCAST   5'h09
`define EIS_C_CRC     5'h0a
`define EIS_C_UNDER   5'h0b
`define EIS_C_OVER    5'h0c
`define EIS_C_FRAG    5'h0d
`define EIS_C_JAB     5'h0e
`define EIS_C_TOTAL   5'h0f
`define EIS_C_RX_OCT  5'h10
`define EIS_C_B64     5'h11
`define EIS_C_B127    5'h12
`define EIS_C_B255    5'h13
`define EIS_C_B511    5'h14
`define EIS_C_B1023   5'h15
`define EIS_C_B1518   5'h16
`define EIS_C_NONE    5'h1f
`define EIS_REG_STAT  5'h18
`define EIS_REG_CTRL  5'h19
`define EIS_REG_MTU   5'h1a
`define EIS_ST_LINK   0
`define EIS_ST_DUPLEX 1
`define EIS_ST_VALID  2
`define EIS_ST_TEST   3
`define EIS_CT_CLEAR  0
`define EIS_CT_TEST   1
`define EIS_CT_VALID  2
`define EIS_LEN_MIN   16'h0040
`define EIS_LEN_127   16'h007f
`define EIS_LEN_255   16'h00ff
`define EIS_LEN_511   16'h01ff
`define EIS_LEN_1023  16'h03ff
`define EIS_LEN_MAX   16'h05ee
`define EIS_MTU_RST   `EIS_LEN_MAX
`endif

/* design/eis_pkg.sv */
// Types shared by the interface statistics block and its bench.
package eis_pkg;
  `include "eis_cfg.svh"

  typedef logic [`EIS_IFW-1:0]  eis_ifc_t;
  typedef logic [`EIS_LENW-1:0] eis_len_t;
  typedef logic [`EIS_CNTW-1:0] eis_cnt_t;

  typedef struct packed {
    logic     valid;
    eis_ifc_t ifc;
    eis_len_t len;
    logic     fcs_ok;
    logic     bcast;
    logic     mcast;
    logic     unknown;
    logic     drop_evt;
  } eis_rx_s;

  typedef struct packed {
    logic     valid;
    eis_ifc_t ifc;
    eis_len_t len;
    logic     mcast;
    logic     discard;
    logic     error;
  } eis_tx_s;

  typedef struct packed {
    logic                read;
    logic                write;
    logic [`EIS_AW-1:0]  address;
    logic [31:0]         writedata;
  } eis_av_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } eis_av_rsp_s;

  typedef enum logic [1:0] {
    EIS_IDLE = 2'b01,
    EIS_ACK  = 2'b10
  } eis_bus_e;

  typedef struct packed {
    eis_cnt_t [`EIS_NIF-1:0][`EIS_NCNT-1:0] cnt;
    eis_len_t [`EIS_NIF-1:0]                mtu;
    logic [`EIS_NIF-1:0]                    testing;
    logic [`EIS_NIF-1:0]                    valid;
    logic [`EIS_NIF-1:0]                    link_s1;
    logic [`EIS_NIF-1:0]                    link_s2;
    logic [`EIS_NIF-1:0]                    dup_s1;
    logic [`EIS_NIF-1:0]                    dup_s2;
    eis_bus_e                               bus;
    logic [31:0]                            rdata;
  } eis_state_s;
endpackage

/* sim/eis_link_model.sv */
// Network-side model that issues frame, collision and pin events.
`timescale 1ns/100ps
module eis_link_model (
  input  wire logic        clk,
  output eis_pkg::eis_rx_s rx_evt,
  output eis_pkg::eis_tx_s tx_evt,
  output logic [3:0]       collision,
  output logic [3:0]       link_pin,
  output logic [3:0]       duplex_pin
);
  import eis_pkg::*;
  initial begin
    rx_evt = '0;
    tx_evt = '0;
    collision = '0;
    link_pin = '0;
    duplex_pin = '0;
  end
  // Each call drives its event until the next call; calls in a row give back-to-back events.
  task automatic ev(input eis_rx_s r, input eis_tx_s t, input logic [3:0] c);
    @(posedge clk);
    rx_evt <= r;
    tx_evt <= t;
    collision <= c;
  endtask
  // Idle fields show the inverse of the last event, so a stale field never passes.
  task automatic idle();
    eis_rx_s r;
    eis_tx_s t;
    r = ~rx_evt;
    t = ~tx_evt;
    r.valid = 1'b0;
    t.valid = 1'b0;
    @(posedge clk);
    rx_evt <= r;
    tx_evt <= t;
    collision <= '0;
  endtask
  task automatic pins(input logic [3:0] l, input logic [3:0] d);
    @(posedge clk);
    link_pin <= l;
    duplex_pin <= d;
  endtask
endmodule

/* sim/eis_stats_test.sv */
// Self-checking bench for the interface statistics block.
`timescale 1ns/100ps
`include "eis_cfg.svh"
module eis_stats_test;
  import eis_pkg::*;
  logic        clk;
  logic        sys_rst;
  eis_av_req_s av_req;
  eis_av_rsp_s av_rsp;
  eis_rx_s     rx_evt;
  eis_tx_s     tx_evt;
  logic [3:0]  collision, link_pin, duplex_pin, pass_en, link_up, full_duplex;
  eis_cnt_t    e [4][23];
  logic [3:0]  tst;
  logic [31:0] q;
  int          miscompares;
  int          samples_checked;
  localparam eis_len_t LENS [13] = '{16'h3f, 16'h40, 16'h41, 16'h7f, 16'h80, 16'hff,
    16'h100, 16'h1ff, 16'h200, 16'h3ff, 16'h400, 16'h5ee, 16'h5ef};

  eis_stats dut (.clk(clk), .sys_rst(sys_rst), .av_req(av_req), .av_rsp(av_rsp),
    .rx_evt(rx_evt), .tx_evt(tx_evt), .collision(collision), .link_pin(link_pin),
    .duplex_pin(duplex_pin), .pass_en(pass_en), .link_up(link_up),
    .full_duplex(full_duplex));
  eis_link_model link (.clk(clk), .rx_evt(rx_evt), .tx_evt(tx_evt),
    .collision(collision), .link_pin(link_pin), .duplex_pin(duplex_pin));

  always #50 clk = ~clk;

  // ----------------------------------------
  // Bus access and comparison
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask
  // The request is held until an edge where waitrequest was seen low.
  task automatic acc(input logic w, input eis_ifc_t f, input logic [4:0] i,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    av_req <= '{~w, w, {f, i, 2'b00}, d};
    // Sampled at the rising edge itself; the answer and read data stand there.
    do begin
      @(posedge clk);
      n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
    q = av_rsp.readdata;
    av_req <= '0;
  endtask
  task automatic rd(input eis_ifc_t f, input logic [4:0] i, input logic [31:0] x,
                    input string s);
    acc(1'b0, f, i, 32'h0);
    chk(s, x, q);
  endtask
  task automatic cmp_all(input eis_ifc_t f);
    for (int k = 0; k < 23; k++) begin
      acc(1'b0, f, 5'(k), 32'h0);
      chk($sformatf("if%0d cnt%0h", f, k), e[f][k], q);
    end
  endtask

  // ----------------------------------------
  // Event stimulus with expected counts
  // ----------------------------------------
  // Flags are broadcast, multicast, unknown format and drop occasion.
  task automatic rx(input eis_ifc_t f, input eis_len_t n, input logic ok,
                    input logic [3:0] fl);
    if (!tst[f]) begin
      e[f][`EIS_C_TOTAL]++;
      e[f][`EIS_C_RX_OCT] += 32'(n);
      if (!ok) e[f][`EIS_C_CRC]++;
      if (fl[1]) e[f][`EIS_C_UNKNOWN]++;
      if (fl[0]) e[f][`EIS_C_DROP]++;
      if (ok && fl[3]) e[f][`EIS_C_BCAST]++;
      else if (ok && fl[2]) e[f][`EIS_C_MCAST]++;
      if (n < 16'h40) e[f][ok ? `EIS_C_UNDER : `EIS_C_FRAG]++;
      else if (n > 16'h5ee) e[f][ok ? `EIS_C_OVER : `EIS_C_JAB]++;
      else e[f][`EIS_C_B64 + (n > 16'h40) + (n > 16'h7f) + (n > 16'hff)
                + (n > 16'h1ff) + (n > 16'h3ff)]++;
    end
    link.ev('{1'b1, f, n, ok, fl[3], fl[2], fl[1], fl[0]}, '0, '0);
  endtask
  task automatic tx(input eis_ifc_t f, input eis_len_t n, input logic m,
                    input logic dc, input logic er);
    if (!tst[f]) begin
      if (er) e[f][`EIS_C_OUT_ERR]++;
      else if (dc) e[f][`EIS_C_OUT_DSC]++;
      else begin
        e[f][`EIS_C_OUT_OCT] += 32'(n);
        e[f][m ? `EIS_C_OUT_NUC : `EIS_C_OUT_UC]++;
      end
    end
    link.ev('0, '{1'b1, f, n, m, dc, er}, '0);
  endtask
  // Collisions count even while an interface is in testing state.
  task automatic col(input logic [3:0] c);
    for (int i = 0; i < 4; i++) if (c[i]) e[i][`EIS_C_COLL]++;
    link.ev('0, '0, c);
  endtask
  task automatic settle(input string s);
    link.idle();
    repeat (2) @(posedge clk);
    $display("test %s done", s);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    av_req = '0;
    tst = '0;
    miscompares = 0;
    samples_checked = 0;
    foreach (e[i, j]) e[i][j] = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    chk("pass_en", 32'hf, {28'h0, pass_en});  // all interfaces pass after reset.
    for (int f = 0; f < 4; f++) begin
      rd(2'(f), `EIS_REG_STAT, 32'h4, "status");  // entry valid after reset.
      rd(2'(f), `EIS_REG_MTU, 32'h5ee, "mtu");  // largest frame size shown.
      cmp_all(2'(f));  // counters clear at reset.
    end
    settle("reset");
    link.pins(4'b0101, 4'b0011);
    repeat (4) @(posedge clk);
    chk("link_up", 32'h5, {28'h0, link_up});  // link indicator follows pins.
    chk("full_duplex", 32'h3, {28'h0, full_duplex});  // duplex follows pins.
    rd(2'd0, `EIS_REG_STAT, 32'h7, "status0");  // link, full duplex, valid.
    rd(2'd2, `EIS_REG_STAT, 32'h5, "status2");  // link with half duplex.
    settle("pins");
    for (int i = 0; i < 13; i++) begin
      rx(2'd1, LENS[i], 1'b1, 4'b0000);
      rx(2'd1, LENS[i], 1'b0, 4'b0000);
    end
    rx(2'd1, 16'h64, 1'b1, 4'b1100);
    rx(2'd1, 16'h64, 1'b1, 4'b0100);
    rx(2'd1, 16'h64, 1'b0, 4'b1000);
    rx(2'd1, 16'h64, 1'b0, 4'b0100);
    rx(2'd1, 16'h46, 1'b1, 4'b0011);
    rx(2'd1, 16'h50, 1'b1, 4'b0001);
    rx(2'd2, 16'h5ee, 1'b1, 4'b0001);
    tx(2'd1, 16'h64, 1'b0, 1'b0, 1'b0);
    tx(2'd1, 16'hc8, 1'b1, 1'b0, 1'b0);
    tx(2'd1, 16'h12c, 1'b0, 1'b1, 1'b0);
    tx(2'd1, 16'h190, 1'b0, 1'b1, 1'b1);
    tx(2'd2, 16'h40, 1'b0, 1'b0, 1'b1);
    col(4'b0110);
    col(4'b0010);
    rx(2'd0, 16'h40, 1'b1, 4'b1101);
    rx(2'd0, 16'h20, 1'b0, 4'b0000);
    rx(2'd0, 16'h600, 1'b0, 4'b0001);
    settle("traffic");
    cmp_all(2'd1);
    cmp_all(2'd2);  // third interface kept apart.
    cmp_all(2'd0);  // first interface classified.
    acc(1'b1, 2'd1, `EIS_REG_CTRL, 32'h5);  // clear one interface.
    for (int j = 0; j < 23; j++) e[1][j] = '0;
    cmp_all(2'd1);  // selected interface cleared.
    cmp_all(2'd2);  // other interface untouched.
    rd(2'd1, `EIS_REG_CTRL, 32'h4, "ctrl1");  // clear bit reads back zero.
    settle("clear");
    acc(1'b1, 2'd3, `EIS_REG_CTRL, 32'h2);
    tst[3] = 1'b1;
    rd(2'd3, `EIS_REG_STAT, 32'h8, "status3");  // testing and invalid shown.
    chk("pass_en", 32'h7, {28'h0, pass_en});  // testing interface passes nothing.
    rx(2'd3, 16'h40, 1'b1, 4'b1000);
    tx(2'd3, 16'h40, 1'b0, 1'b0, 1'b0);
    col(4'b1000);
    settle("testing");
    cmp_all(2'd3);  // only the collision is counted.
    acc(1'b1, 2'd3, `EIS_REG_CTRL, 32'h4);
    tst[3] = 1'b0;
    rx(2'd3, 16'h80, 1'b0, 4'b0000);
    tx(2'd3, 16'h80, 1'b1, 1'b0, 1'b0);
    settle("resume");
    cmp_all(2'd3);  // counting resumes after testing ends.
    chk("pass_en", 32'hf, {28'h0, pass_en});  // interface passes again.
    acc(1'b1, 2'd0, `EIS_REG_MTU, 32'h400);
    rd(2'd0, `EIS_REG_MTU, 32'h400, "mtu0");  // frame size limit written back.
    rd(2'd1, `EIS_REG_MTU, 32'h5ee, "mtu1");  // other interface keeps its limit.
    rd(2'd2, 5'h17, 32'h0, "unmapped");
    acc(1'b1, 2'd2, `EIS_C_TOTAL, 32'h1234);
    acc(1'b1, 2'd0, `EIS_REG_STAT, 32'h0);
    rd(2'd0, `EIS_REG_STAT, 32'h7, "status ro");  // status ignores writes.
    cmp_all(2'd2);  // counters ignore writes.
    settle("registers");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule
